/* logic/bias_measure_seq.sv */
// Kick-back measurement sequencer that runs on the start bit and then clears it.
`timescale 1ns/1ps
`default_nettype none

module bias_measure_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic result_in,
  output logic run_out,
  output logic start_clear_out,
  output logic complete_out
);

  irq_pkg::meas_state_t state_reg;
  irq_pkg::meas_state_t state_next;
  logic run_reg;
  logic clear_reg;
  logic complete_reg;
  logic finished;

  assign finished = (state_reg == irq_pkg::MEAS_RUN) && result_in;

  // The finish state waits for the start bit to drop, so a stale start level is never rerun.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      irq_pkg::MEAS_IDLE: begin
        if (start_in) begin
          state_next = irq_pkg::MEAS_RUN;
        end
      end
      irq_pkg::MEAS_RUN: begin
        if (result_in) begin
          state_next = irq_pkg::MEAS_FINISH;
        end
      end
      irq_pkg::MEAS_FINISH: begin
        if (!start_in) begin
          state_next = irq_pkg::MEAS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= irq_pkg::MEAS_IDLE;
      run_reg <= 1'b0;
      clear_reg <= 1'b0;
      complete_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg <= (state_next == irq_pkg::MEAS_RUN);
      clear_reg <= finished;
      complete_reg <= finished;
    end
  end

  assign run_out = run_reg;
  assign start_clear_out = clear_reg;
  assign complete_out = complete_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_start_runs: assert property ((state_reg == irq_pkg::MEAS_IDLE) && start_in |=> run_out)
    else $error("Measurement did not start on the start bit.");
  a_start_cleared: assert property (finished |=> start_clear_out && complete_out ##1 !start_clear_out)
    else $error("Start bit was not cleared once after the measurement.");

endmodule : bias_measure_seq

`default_nettype wire

/* logic/pmic_fault_event_interrupts.sv */
// Fault and event flags, interrupt masks and open-drain interrupt request of the power chip.
`timescale 1ns/1ps
`default_nettype none

module pmic_fault_event_interrupts #(
  parameter int TEMP_WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic overheat_shutdown_in,
  input wire logic overheat_warn_in,
  input wire logic sensor_high_temp_in,
  input wire logic sensor_low_temp_in,
  input wire logic input_low_in,
  input wire logic pos_boost_low_in,
  input wire logic high_gate_low_in,
  input wire logic inv_conv_low_in,
  input wire logic pos_source_low_in,
  input wire logic neg_gate_low_in,
  input wire logic bias_fault_in,
  input wire logic neg_source_low_in,
  input wire logic [TEMP_WIDTH-1:0] temp_sample_in,
  input wire logic temp_sample_valid_in,
  input wire logic bias_measure_start_in,
  input wire logic bias_measure_result_in,
  output logic bias_measure_run_out,
  output logic bias_measure_start_clear_out,
  input wire logic bias_commit_done_in,
  output logic irq_n_out,
  output logic irq_oe_out
);

  if (TEMP_WIDTH < 3) begin : g_bad_width
    $error("TEMP_WIDTH must hold the change threshold.");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A hardware set always beats a clear in the same cycle, so no event is lost to a read.
  function automatic logic [7:0] set_wins(input logic [7:0] cur, input logic [7:0] set,
                                          input logic [7:0] clr);
    set_wins = set | (cur & ~clr);
  endfunction : set_wins

  function automatic logic [TEMP_WIDTH-1:0] abs_diff(input logic [TEMP_WIDTH-1:0] a,
                                                      input logic [TEMP_WIDTH-1:0] b);
    abs_diff = (a >= b) ? a - b : b - a;
  endfunction : abs_diff

  // ----------------------------------------------------------------
  // Detector synchronisers
  // ----------------------------------------------------------------
  // The analog detectors are asynchronous to this clock.
  localparam int NUM_LEVELS = 12;
  logic [NUM_LEVELS-1:0] level_raw;
  logic [NUM_LEVELS-1:0] level_meta_reg;
  logic [NUM_LEVELS-1:0] level_sync_reg;
  logic [4:0] thermal_now;
  logic [6:0] rail_now;

  assign level_raw = {overheat_shutdown_in, overheat_warn_in, sensor_high_temp_in,
                      sensor_low_temp_in, input_low_in, pos_boost_low_in, high_gate_low_in,
                      inv_conv_low_in, pos_source_low_in, neg_gate_low_in, bias_fault_in,
                      neg_source_low_in};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_meta_reg <= '0;
      level_sync_reg <= '0;
    end else begin
      level_meta_reg <= level_raw;
      level_sync_reg <= level_meta_reg;
    end
  end

  assign thermal_now = level_sync_reg[11:7];
  assign rail_now = level_sync_reg[6:0];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic hit_mask1;
  logic hit_mask2;
  logic hit_flags1;
  logic hit_flags2;
  logic wr_mask1;
  logic wr_mask2;
  logic rd_flags1;
  logic rd_flags2;

  assign hit_mask1 = (reg_addr_in == irq_pkg::OFS_MASK1);
  assign hit_mask2 = (reg_addr_in == irq_pkg::OFS_MASK2);
  assign hit_flags1 = (reg_addr_in == irq_pkg::OFS_FLAGS1);
  assign hit_flags2 = (reg_addr_in == irq_pkg::OFS_FLAGS2);
  assign wr_mask1 = reg_wr_in && hit_mask1;
  assign wr_mask2 = reg_wr_in && hit_mask2;
  assign rd_flags1 = reg_rd_in && hit_flags1;
  assign rd_flags2 = reg_rd_in && hit_flags2;

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  logic [4:0] mask1_rw_reg;
  logic [7:0] mask2_reg;
  logic [7:0] mask1_view;
  logic [4:0] wdata_rw;

  assign wdata_rw = reg_wdata_in[irq_pkg::BIT_OVERHEAT:irq_pkg::BIT_INPUT_LOW];
  // Only the middle five enables exist as storage; the outer bits are constants.
  assign mask1_view = {irq_pkg::MASK1_FIXED_HI, mask1_rw_reg, irq_pkg::MASK1_FIXED_LO};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask1_rw_reg <= irq_pkg::MASK1_RST[irq_pkg::BIT_OVERHEAT:irq_pkg::BIT_INPUT_LOW];
      mask2_reg <= irq_pkg::MASK2_RST;
    end else begin
      if (wr_mask1) begin
        mask1_rw_reg <= wdata_rw;
      end
      if (wr_mask2) begin
        mask2_reg <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature change detection
  // ----------------------------------------------------------------
  // The first reading after reset has nothing to compare against and never flags a change.
  logic [TEMP_WIDTH-1:0] prev_temp_reg;
  logic have_prev_reg;
  logic temp_jump;

  assign temp_jump = temp_sample_valid_in && have_prev_reg &&
                     (abs_diff(temp_sample_in, prev_temp_reg) >=
                      TEMP_WIDTH'(irq_pkg::TEMP_DELTA_MIN));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_temp_reg <= '0;
      have_prev_reg <= 1'b0;
    end else if (temp_sample_valid_in) begin
      prev_temp_reg <= temp_sample_in;
      have_prev_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  logic measure_complete;

  bias_measure_seq u_measure (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(bias_measure_start_in),
    .result_in(bias_measure_result_in),
    .run_out(bias_measure_run_out),
    .start_clear_out(bias_measure_start_clear_out),
    .complete_out(measure_complete)
  );

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // Condition flags are set every cycle the condition holds, so a read only clears
  // them once the condition has gone away.
  logic [7:0] flags1_reg;
  logic [7:0] flags2_reg;
  logic [7:0] flags1_set;
  logic [7:0] flags2_set;
  logic [7:0] flags1_next;
  logic [7:0] flags2_next;
  logic [1:0] done_pair;

  assign done_pair = {measure_complete, bias_commit_done_in};
  assign flags1_set = {temp_jump, thermal_now, done_pair};
  assign flags2_set = {rail_now, temp_sample_valid_in};
  assign flags1_next = set_wins(flags1_reg, flags1_set, {8{rd_flags1}});
  assign flags2_next = set_wins(flags2_reg, flags2_set, {8{rd_flags2}});

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags1_reg <= irq_pkg::FLAGS1_RST;
      flags2_reg <= irq_pkg::FLAGS2_RST;
    end else begin
      flags1_reg <= flags1_next;
      flags2_reg <= flags2_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Flags are still stored when masked; only the pin drive is gated.
  logic pending;
  logic irq_n_reg;
  logic irq_oe_reg;

  assign pending = (|(flags1_reg & mask1_view)) || (|(flags2_reg & mask2_reg));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_n_reg <= 1'b1;
      irq_oe_reg <= 1'b0;
    end else begin
      irq_n_reg <= !pending;
      irq_oe_reg <= pending;
    end
  end

  assign irq_n_out = irq_n_reg;
  assign irq_oe_out = irq_oe_reg;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data hold the last answer between reads; unmapped offsets read as zero.
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  assign rdata_next = hit_mask1 ? mask1_view :
                      hit_mask2 ? mask2_reg :
                      hit_flags1 ? flags1_reg :
                      hit_flags2 ? flags2_reg : 8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_irq_drive_low: assert property (pending |=> !irq_n_out && irq_oe_out)
    else $error("Enabled flag did not pull the interrupt pin low.");
  a_masked_still_flagged: assert property (!mask2_reg[irq_pkg::BIT_POS_BOOST_LOW] &&
      flags2_set[irq_pkg::BIT_POS_BOOST_LOW] |=> flags2_reg[irq_pkg::BIT_POS_BOOST_LOW])
    else $error("Masked event was not flagged.");
  a_irq_release: assert property (!pending |=> irq_n_out && !irq_oe_out)
    else $error("Interrupt pin held with no enabled flag.");
  a_temp_mask_zero: assert property (reg_rd_in && hit_mask1 |=> !reg_rdata_out[irq_pkg::BIT_TEMP_CHANGE])
    else $error("Temperature-change enable did not read zero.");
  a_done_mask_ones: assert property (reg_rd_in && hit_mask1 |=> reg_rdata_out[1:0] == 2'b11)
    else $error("Completion enables did not read one.");
  a_mask1_write: assert property (wr_mask1 |=> mask1_rw_reg == $past(wdata_rw))
    else $error("Writable thermal enables did not take the written value.");
  a_mask2_write: assert property (wr_mask2 |=> mask2_reg == $past(reg_wdata_in))
    else $error("Rail enables did not take the written value.");
  a_temp_change_flag: assert property (temp_jump |=> flags1_reg[irq_pkg::BIT_TEMP_CHANGE])
    else $error("Temperature change was not flagged.");
  a_shutdown_flag: assert property (thermal_now[4] |=> flags1_reg[irq_pkg::BIT_OVERHEAT] [*1])
    else $error("Shutdown condition was not flagged.");
  a_thermal_flags: assert property (1'b1 |=>
      (flags1_reg[5:2] & $past(thermal_now[3:0])) == $past(thermal_now[3:0]))
    else $error("Thermal or input condition was not flagged.");
  a_done_flags: assert property (1'b1 |=>
      (flags1_reg[1:0] & $past(done_pair)) == $past(done_pair))
    else $error("Completion event was not flagged.");
  a_flags_read_clear: assert property (rd_flags1 && (flags1_set == 8'h00) |=>
      flags1_reg == 8'h00 && reg_rdata_out == $past(flags1_reg))
    else $error("First flag register did not clear on read.");
  a_rail_flags: assert property (rail_now[6] && rd_flags2 |=> flags2_reg[irq_pkg::BIT_POS_BOOST_LOW])
    else $error("Rail flag was lost to a simultaneous read.");

  // A flag that drops by itself loses an event, so it must last until its register is read.
  a_flags1_sticky: assert property (!rd_flags1 |=>
      (flags1_reg & $past(flags1_reg)) == $past(flags1_reg))
    else $error("First flag register lost a flag without a read.");

  a_flags2_sticky: assert property (!rd_flags2 |=>
      (flags2_reg & $past(flags2_reg)) == $past(flags2_reg))
    else $error("Second flag register lost a flag without a read.");

  // Only a detected event may raise a flag, so the host never chases a phantom cause.
  a_flags1_no_phantom: assert property (1'b1 |=>
      (flags1_reg & ~$past(flags1_reg) & ~$past(flags1_set)) == 8'h00)
    else $error("First flag register raised a flag with no event.");

  a_flags2_no_phantom: assert property (1'b1 |=>
      (flags2_reg & ~$past(flags2_reg) & ~$past(flags2_set)) == 8'h00)
    else $error("Second flag register raised a flag with no event.");

  a_rail_flags_all: assert property (1'b1 |=>
      (flags2_reg[7:1] & $past(rail_now)) == $past(rail_now))
    else $error("Rail condition was not flagged.");

  a_conv_done_flag: assert property (temp_sample_valid_in |=> flags2_reg[irq_pkg::BIT_TEMP_CONV_DONE])
    else $error("Conversion completion was not flagged.");

  a_unmapped_zero: assert property (reg_rd_in && !(hit_mask1 || hit_mask2 || hit_flags1 || hit_flags2) |=>
      reg_rdata_out == 8'h00)
    else $error("Unmapped offset did not read zero.");

  a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read.");

  a_mask2_readback: assert property (reg_rd_in && hit_mask2 |=> reg_rdata_out == $past(mask2_reg))
    else $error("Rail enables did not read back.");

  a_mask1_hold: assert property (!wr_mask1 |=> $stable(mask1_rw_reg))
    else $error("Thermal enables changed without a write.");

  a_mask2_hold: assert property (!wr_mask2 |=> $stable(mask2_reg))
    else $error("Rail enables changed without a write.");

  // The completion enables are fixed at one, so either completion flag must reach the pin.
  a_done_drives_pin: assert property ((|flags1_reg[1:0]) |=> !irq_n_out && irq_oe_out)
    else $error("Completion flag did not pull the interrupt pin low.");

  a_temp_never_drives: assert property (flags1_reg == 8'h80 && (flags2_reg & mask2_reg) == 8'h00 |=>
      irq_n_out && !irq_oe_out)
    else $error("Temperature-change flag drove the interrupt pin.");

  a_clear_then_flag: assert property (bias_measure_start_clear_out |=>
      flags1_reg[irq_pkg::BIT_MEASURE_DONE])
    else $error("Start clear was not followed by the measure-done flag.");

  a_sync_two_stage: assert property (1'b1 |=>
      level_meta_reg == $past(level_raw) && level_sync_reg == $past(level_meta_reg))
    else $error("Detector synchroniser did not take two stages.");

  c_irq_cycle: cover property (irq_oe_out ##1 rd_flags1 ##[1:4] !irq_oe_out);
  c_temp_jump: cover property (temp_jump);
  c_measure: cover property (bias_measure_run_out ##[1:20] measure_complete);
  c_masked_event: cover property (flags2_reg[irq_pkg::BIT_NEG_SOURCE_LOW] && !pending);
  c_read_during_rail: cover property (rail_now[6] && rd_flags2);

endmodule : pmic_fault_event_interrupts

`default_nettype wire

/* shared/irq_pkg.sv */
// Register map, field positions and reset values of the fault event interrupt block.

`default_nettype none

package irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MASK1 = 8'h05;
  localparam logic [7:0] OFS_MASK2 = 8'h06;
  localparam logic [7:0] OFS_FLAGS1 = 8'h07;
  localparam logic [7:0] OFS_FLAGS2 = 8'h08;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK1_RST = 8'h7f;
  localparam logic [7:0] MASK2_RST = 8'hff;
  localparam logic [7:0] FLAGS1_RST = 8'h00;
  localparam logic [7:0] FLAGS2_RST = 8'h00;

  // ----------------------------------------------------------------
  // First mask and flag register fields
  // ----------------------------------------------------------------
  localparam int BIT_TEMP_CHANGE = 7;
  localparam int BIT_OVERHEAT = 6;
  localparam int BIT_INPUT_LOW = 2;
  localparam int BIT_MEASURE_DONE = 1;
  localparam int BIT_COMMIT_DONE = 0;
  localparam logic MASK1_FIXED_HI = 1'b0;
  localparam logic [1:0] MASK1_FIXED_LO = 2'b11;

  // ----------------------------------------------------------------
  // Second flag register fields
  // ----------------------------------------------------------------
  localparam int BIT_POS_BOOST_LOW = 7;
  localparam int BIT_NEG_SOURCE_LOW = 1;
  localparam int BIT_TEMP_CONV_DONE = 0;

  // ----------------------------------------------------------------
  // Temperature change threshold in degrees
  // ----------------------------------------------------------------
  localparam int TEMP_DELTA_MIN = 3;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_RUN,
    MEAS_FINISH
  } meas_state_t;

endpackage : irq_pkg

`default_nettype wire

/* tb/far_side_model.sv */
// Far side of the block: pulled-up interrupt wire, measure-start bit holder and measurement engine.
`timescale 1ns/1ps
`default_nettype none

module far_side_model #(
  parameter int MEASURE_CYCLES = 6
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic irq_n_in,
  input wire logic irq_oe_in,
  input wire logic set_start_in,
  input wire logic run_in,
  input wire logic start_clear_in,
  output logic start_out,
  output logic result_out,
  output logic irq_wire_out
);
  int count_reg;

  // The pin is open drain, so the pull-up decides the level whenever the device lets go.
  assign irq_wire_out = irq_oe_in ? irq_n_in : 1'b1;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_out <= 1'b0;
      result_out <= 1'b0;
      count_reg <= 0;
    end else begin
      result_out <= 1'b0;
      if (set_start_in) begin
        start_out <= 1'b1;
      end else if (start_clear_in) begin
        start_out <= 1'b0;
      end
      if (!run_in) begin
        count_reg <= 0;
      end else if (count_reg == MEASURE_CYCLES - 1) begin
        result_out <= 1'b1;
        count_reg <= 0;
      end else begin
        count_reg <= count_reg + 1;
      end
    end
  end
endmodule : far_side_model

`default_nettype wire

/* tb/pmic_fault_event_interrupts_bench.sv */
// Self-checking bench for the fault event interrupt block.
`timescale 1ns/1ps
`default_nettype none

module pmic_fault_event_interrupts_bench;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
    logic [7:0] care;
  } row_t;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [11:0] src_vec = 12'h000;
  logic [7:0] temp = 8'h00;
  logic temp_valid = 1'b0;
  logic commit_done = 1'b0;
  logic set_start = 1'b0;
  logic start_bit;
  logic result;
  logic run;
  logic clr;
  logic irq_n;
  logic irq_oe;
  logic irq_wire;
  int miscompares = 0;
  int samples_checked = 0;
  row_t rows [7] = '{
    '{8'h05, 8'h00, 8'h03, 8'hff}, '{8'h05, 8'hff, 8'h7f, 8'hff}, '{8'h06, 8'h00, 8'h00, 8'hff},
    '{8'h06, 8'h5a, 8'h5a, 8'hff}, '{8'h07, 8'hff, 8'h00, 8'h83}, '{8'h20, 8'hff, 8'h00, 8'hff},
    '{8'h06, 8'hff, 8'hff, 8'hff}};

  always #2.5 clk_in = ~clk_in;

  pmic_fault_event_interrupts dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .overheat_shutdown_in(src_vec[11]), .overheat_warn_in(src_vec[10]), .sensor_high_temp_in(src_vec[9]),
    .sensor_low_temp_in(src_vec[8]), .input_low_in(src_vec[7]), .pos_boost_low_in(src_vec[6]),
    .high_gate_low_in(src_vec[5]), .inv_conv_low_in(src_vec[4]), .pos_source_low_in(src_vec[3]),
    .neg_gate_low_in(src_vec[2]), .bias_fault_in(src_vec[1]), .neg_source_low_in(src_vec[0]),
    .temp_sample_in(temp), .temp_sample_valid_in(temp_valid), .bias_measure_start_in(start_bit),
    .bias_measure_result_in(result), .bias_measure_run_out(run), .bias_measure_start_clear_out(clr),
    .bias_commit_done_in(commit_done), .irq_n_out(irq_n), .irq_oe_out(irq_oe));

  far_side_model #(.MEASURE_CYCLES(6)) model_u (
    .clk_in(clk_in), .rst_in(rst_in), .irq_n_in(irq_n), .irq_oe_in(irq_oe), .set_start_in(set_start),
    .run_in(run), .start_clear_in(clr), .start_out(start_bit), .result_out(result), .irq_wire_out(irq_wire));

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] care, input string what);
    samples_checked++;
    if ((got & care) !== (exp & care)) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check8

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : wait_cycles

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : reg_write

  // Read data is registered at the edge that takes the strobe, so it is looked at half a cycle later.
  task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] care, input string what);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    check8(rdata, exp, care, what);
  endtask : read_check

  task automatic check_irq(input logic exp, input string what);
    check8({5'h00, irq_oe, irq_n, irq_wire}, {5'h00, !exp, exp, exp}, 8'h07, what);
  endtask : check_irq

  task automatic sample(input logic [7:0] d);
    @(posedge clk_in);
    temp <= d;
    temp_valid <= 1'b1;
    @(posedge clk_in);
    temp_valid <= 1'b0;
  endtask : sample

  initial begin
    #(20000 * 5);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] b;
    int n;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    // ----------------------------------------------------------------
    // Mask writes, read-only places and an unmapped address
    // ----------------------------------------------------------------
    foreach (rows[i]) begin
      reg_write(rows[i].addr, rows[i].wdata);
      read_check(rows[i].addr, rows[i].exp, rows[i].care, "register row");
    end
    // ----------------------------------------------------------------
    // Every level source, first masked and then enabled
    // ----------------------------------------------------------------
    for (int i = 0; i < 12; i++) begin
      a = (i < 7) ? irq_pkg::OFS_FLAGS2 : irq_pkg::OFS_FLAGS1;
      b = 8'h01 << ((i < 7) ? i + 1 : i - 5);
      for (int m = 0; m < 2; m++) begin
        reg_write(a - 8'h02, (m == 1) ? 8'hff : ~b);
        @(posedge clk_in);
        src_vec <= 12'h001 << i;
        wait_cycles(6);
        check_irq((m == 1) ? 1'b0 : 1'b1, "source irq");
        @(posedge clk_in);
        src_vec <= 12'h000;
        wait_cycles(5);
        read_check(a, b, b, "source flag");
        read_check(a, 8'h00, b, "flag cleared");
        check_irq(1'b1, "irq released");
      end
    end
    // ----------------------------------------------------------------
    // Temperature change against the previous reading
    // ----------------------------------------------------------------
    reg_write(irq_pkg::OFS_MASK2, 8'hfe);
    sample(8'd100);
    sample(8'd102);
    read_check(irq_pkg::OFS_FLAGS1, 8'h00, 8'h80, "small change");
    sample(8'd105);
    wait_cycles(3);
    check_irq(1'b1, "change never drives pin");
    read_check(irq_pkg::OFS_FLAGS1, 8'h80, 8'h80, "rise of three");
    sample(8'd103);
    read_check(irq_pkg::OFS_FLAGS1, 8'h00, 8'h80, "fall of two");
    sample(8'd100);
    read_check(irq_pkg::OFS_FLAGS1, 8'h80, 8'h80, "fall of three");
    read_check(irq_pkg::OFS_FLAGS2, 8'h01, 8'h01, "conversion done");
    reg_write(irq_pkg::OFS_MASK2, 8'hff);
    // ----------------------------------------------------------------
    // Commit completion and measurement completion
    // ----------------------------------------------------------------
    @(posedge clk_in);
    commit_done <= 1'b1;
    @(posedge clk_in);
    commit_done <= 1'b0;
    wait_cycles(3);
    check_irq(1'b0, "commit irq");
    read_check(irq_pkg::OFS_FLAGS1, 8'h01, 8'h01, "commit done");
    read_check(irq_pkg::OFS_FLAGS1, 8'h00, 8'h01, "commit cleared");
    check_irq(1'b1, "commit released");
    @(posedge clk_in);
    set_start <= 1'b1;
    @(posedge clk_in);
    set_start <= 1'b0;
    @(negedge clk_in);
    check8({7'h00, start_bit}, 8'h01, 8'h01, "start bit set");
    @(negedge clk_in);
    check8({7'h00, run}, 8'h01, 8'h01, "measure running");
    n = 0;
    while (start_bit !== 1'b0 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    check8({7'h00, start_bit}, 8'h00, 8'h01, "start bit cleared");
    check8({7'h00, run}, 8'h00, 8'h01, "measure stopped");
    wait_cycles(3);
    check_irq(1'b0, "measure irq");
    read_check(irq_pkg::OFS_FLAGS1, 8'h02, 8'h02, "measure done");
    read_check(irq_pkg::OFS_FLAGS1, 8'h00, 8'h02, "measure cleared");
    // ----------------------------------------------------------------
    // A read while a rail condition still holds keeps the flag
    // ----------------------------------------------------------------
    @(posedge clk_in);
    src_vec <= 12'h040;
    wait_cycles(4);
    read_check(irq_pkg::OFS_FLAGS2, 8'h80, 8'h80, "rail flag held");
    read_check(irq_pkg::OFS_FLAGS2, 8'h80, 8'h80, "rail flag re-set");
    @(posedge clk_in);
    src_vec <= 12'h000;
    wait_cycles(5);
    read_check(irq_pkg::OFS_FLAGS2, 8'h80, 8'h80, "rail flag last");
    read_check(irq_pkg::OFS_FLAGS2, 8'h00, 8'h80, "rail flag gone");
    check_irq(1'b1, "rail released");
    // ----------------------------------------------------------------
    // Second reset in mid-run after the masks were changed
    // ----------------------------------------------------------------
    reg_write(irq_pkg::OFS_MASK1, 8'h00);
    reg_write(irq_pkg::OFS_MASK2, 8'h00);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    read_check(irq_pkg::OFS_MASK1, irq_pkg::MASK1_RST, 8'hff, "mask1 reset");
    read_check(irq_pkg::OFS_MASK2, irq_pkg::MASK2_RST, 8'hff, "mask2 reset");
    read_check(irq_pkg::OFS_FLAGS1, 8'h00, 8'h83, "flags1 reset");
    check_irq(1'b1, "irq after reset");
    tally_and_finish();
  end
endmodule : pmic_fault_event_interrupts_bench

`default_nettype wire
